// ==== tat_timing.sv ====
// Purpose: Touch acquisition timing and detect logic with its APB register file
// Assumes: clk is the touch module clock; comparator and sync inputs are synchronous to clk
// Notes: Channel 0 is autonomous/DMA, 1 is group A, 2 is group B
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns
`include "tat_consts.svh"

// Overview of operation
// RULE1: Autonomous channel settles for settle-length sample cycles after each charge transfer.
// RULE2: Discharge time is discharge length shifted left by the discharge shift amount.
// RULE3: With sync bit set, autonomous acquisition starts on a falling sync edge.
// RULE4: With spread bit set, sample clock is dithered for spread-spectrum drive.
// RULE5: Discharge lasts discharge-length sample cycles before each charging phase; the code discharges only before the first charge of each acquisition.
// RULE6: Acquisition stops once its count reaches the 16-bit maximum count.
// RULE7: Touch reported after consecutive positive detects equal the filter value.
// RULE8: Software never programs the filter value to zero.
// RULE9: Release sensitivity is the out-of-touch detector threshold.
// RULE10: Touch sensitivity is the touch detector threshold.
// RULE11: Positive move from reference by the threshold recalibrates the reference.
// RULE12: Rising drift runs every field times 65536 sample periods; zero disables.
// RULE13: Falling drift runs every field times 65536 sample periods; zero disables.
// RULE14: Group sample clock is module clock over twice divider plus one.
// RULE15: Each group charges for its own charge-length sample cycles.
// RULE16: Each group settles for its own settle-length sample cycles.
// RULE17: Each group applies its own discharge shift to its discharge length.
// RULE18: Each group honours its own sync and spread bits.
// RULE19: Autonomous channel charges for its charge-length sample cycles.
// RULE20: Autonomous sample clock is module clock over twice divider plus one.
// RULE21: Each pair's 3-bit mode code selects disabled, group A, B, matrix or DMA; the code leaves matrix-coded pairs undriven, as if disabled.
// RULE22: Each group discharges for its own length and caps at its own maximum.
module tat_timing import tat_pkg::*; (
    input wire logic clk, // Module clock
    input wire logic rst_b, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic syncIn, // Acquisition sync line
    input wire logic [2:0] compIn, // Per-channel comparator, high ends a burst
    output logic [16:0] pairCharge, // Charge drive per sense pair
    output logic [16:0] pairDischarge, // Discharge drive per sense pair
    output logic touchState // Autonomous sensor in touch
);

    tat_state_t s;
    tat_state_t n;

    // Channel served by a pair mode code, 3 means none
    function automatic logic [1:0] chanOf(input logic [2:0] mode);
        case (mode)
            `TAT_MODE_DMA: chanOf = 2'd0;
            `TAT_MODE_GRPA: chanOf = 2'd1;
            `TAT_MODE_GRPB: chanOf = 2'd2;
            default: chanOf = 2'd3;
        endcase
    endfunction

    function automatic logic [31:0] clkCfg(input tat_state_t st, input int i);
        clkCfg = (i == 0) ? st.aClk : ((i == 1) ? st.gaClk : st.gbClk);
    endfunction

    function automatic logic [31:0] disCfg(input tat_state_t st, input int i);
        disCfg = (i == 0) ? st.aTime : ((i == 1) ? st.gaDis : st.gbDis);
    endfunction

    function automatic logic [10:0] discDur(input logic [31:0] c1);
        discDur = {3'h0, c1[`TAT_DLEN_LSB +: 8]} << c1[`TAT_SHIFT_LSB +: 2];
    endfunction

    function automatic logic [16:0] preTerm(input logic [31:0] c0);
        preTerm = {c0[`TAT_DIV_LSB +: 16], 1'b1};
    endfunction

    logic [2:0] pairMode [16:0];
    logic [2:0] chanUsed;
    logic [16:0] disMask;
    logic syncFall;
    logic recalEv;
    logic [2:0] tick;
    logic [16:0] termEff;
    logic [15:0] newCnt;
    logic [15:0] delta;
    logic [31:0] c0;
    logic [31:0] c1;
    logic [1:0] ch;
    logic [31:0] rdata;
    logic hit;

    always_comb begin
        for (int k = 0; k < `TAT_PAIRS; k++) begin
            pairMode[k] = {s.pmode2[k], s.pmode1[k], s.pmode0[k]};
        end
    end

    always_comb begin
        n = s;
        chanUsed = 3'h0;
        disMask = 17'h0;
        tick = 3'h0;
        termEff = 17'h0;
        newCnt = 16'h0;
        delta = 16'h0;
        c0 = 32'h0;
        c1 = 32'h0;
        ch = 2'd3;
        rdata = 32'h0;
        hit = 1'b0;
        recalEv = 1'b0;
        syncFall = s.syncPrev & ~syncIn;
        n.syncPrev = syncIn;
        for (int k = 0; k < `TAT_PAIRS; k++) begin
            ch = chanOf(pairMode[k]); // [RULE21]
            if (ch != 2'd3) begin
                chanUsed[ch] = 1'b1;
            end else begin
                disMask[k] = 1'b1;
            end
        end

        // APB: access phase takes two cycles, pready comes from a flop
        n.pready = psel & penable & ~s.pready;
        n.pslverr = 1'b0;
        if (psel && penable && !s.pready) begin
            hit = 1'b1;
            case (paddr)
                `TAT_OFF_CTRL: rdata = {31'h0, s.ctrlEn};
                `TAT_OFF_PMODE0: rdata = {15'h0, s.pmode0};
                `TAT_OFF_PMODE1: rdata = {15'h0, s.pmode1};
                `TAT_OFF_PMODE2: rdata = {15'h0, s.pmode2};
                `TAT_OFF_ACLK: rdata = s.aClk;
                `TAT_OFF_ATIME: rdata = s.aTime;
                `TAT_OFF_ADET: rdata = s.aDet;
                `TAT_OFF_ADRIFT: rdata = s.aDrift;
                `TAT_OFF_GACLK: rdata = s.gaClk;
                `TAT_OFF_GADIS: rdata = s.gaDis;
                `TAT_OFF_GBCLK: rdata = s.gbClk;
                `TAT_OFF_GBDIS: rdata = s.gbDis;
                `TAT_OFF_STATUS: begin
                    rdata = {25'h0, s.chan[2].phase != TAT_IDLE, s.chan[1].phase != TAT_IDLE,
                        s.chan[0].phase != TAT_IDLE, 1'b0, s.touch, s.cal, s.ctrlEn};
                end
                `TAT_OFF_COUNTS: rdata = {s.chan[2].result, s.chan[1].result};
                `TAT_OFF_BASE: rdata = {16'h0, s.refCnt};
                `TAT_OFF_CURR: rdata = {16'h0, s.chan[0].result};
                default: hit = 1'b0;
            endcase
            n.prdata = rdata;
            n.pslverr = ~hit;
        end
        if (psel && penable && s.pready && pwrite) begin
            case (paddr)
                `TAT_OFF_CTRL: n.ctrlEn = pwdata[0];
                `TAT_OFF_PMODE0: n.pmode0 = pwdata[16:0];
                `TAT_OFF_PMODE1: n.pmode1 = pwdata[16:0];
                `TAT_OFF_PMODE2: n.pmode2 = pwdata[16:0];
                `TAT_OFF_ACLK: n.aClk = pwdata;
                `TAT_OFF_ATIME: n.aTime = pwdata & `TAT_MASK_TIME;
                `TAT_OFF_ADET: n.aDet = pwdata & `TAT_MASK_DET;
                `TAT_OFF_ADRIFT: n.aDrift = pwdata & `TAT_MASK_DRIFT;
                `TAT_OFF_GACLK: n.gaClk = pwdata;
                `TAT_OFF_GADIS: n.gaDis = pwdata & `TAT_MASK_TIME;
                `TAT_OFF_GBCLK: n.gbClk = pwdata;
                `TAT_OFF_GBDIS: n.gbDis = pwdata & `TAT_MASK_TIME;
                default: ;
            endcase
        end

        // Acquisition channels
        for (int i = 0; i < 3; i++) begin
            c0 = clkCfg(s, i);
            c1 = disCfg(s, i); // [RULE17] [RULE18] [RULE22]
            n.chan[i].done = 1'b0;
            if (!(s.ctrlEn && chanUsed[i])) begin
                n.chan[i].phase = TAT_IDLE;
                n.chan[i].pre = 17'h0;
                n.chan[i].left = 11'h0;
                n.chan[i].cnt = 16'h0;
            end else begin
                // Spread drive shortens random sample periods by one clock
                termEff = preTerm(c0) - {16'h0, c1[`TAT_SPREAD_BIT] & s.chan[i].lfsr[0]}; // [RULE4]
                if (s.chan[i].pre >= termEff) begin
                    tick[i] = 1'b1;
                    n.chan[i].pre = 17'h0;
                    if (c1[`TAT_SPREAD_BIT]) begin
                        n.chan[i].lfsr = {s.chan[i].lfsr[14:0], ~(s.chan[i].lfsr[15]
                            ^ s.chan[i].lfsr[14] ^ s.chan[i].lfsr[12] ^ s.chan[i].lfsr[3])};
                    end
                end else begin
                    n.chan[i].pre = s.chan[i].pre + 17'h1; // [RULE14] [RULE20]
                end
                case (s.chan[i].phase)
                    TAT_IDLE: begin
                        n.chan[i].cnt = 16'h0;
                        if (c1[`TAT_SYNC_BIT]) begin
                            n.chan[i].phase = TAT_SYNC;
                        end else begin
                            n.chan[i].phase = TAT_DIS;
                            n.chan[i].left = discDur(c1); // [RULE2] [RULE5]
                        end
                    end
                    TAT_SYNC: begin
                        if (syncFall) begin
                            n.chan[i].phase = TAT_DIS; // [RULE3]
                            n.chan[i].left = discDur(c1);
                        end
                    end
                    TAT_DIS: begin
                        if (s.chan[i].left == 11'h0) begin
                            n.chan[i].phase = TAT_CHG;
                            n.chan[i].left = {3'h0, c0[`TAT_CHG_LSB +: 8]}; // [RULE15] [RULE19]
                        end else if (tick[i]) begin
                            n.chan[i].left = s.chan[i].left - 11'h1; // [RULE5]
                        end
                    end
                    TAT_CHG: begin
                        if (s.chan[i].left == 11'h0) begin
                            n.chan[i].phase = TAT_SET;
                            n.chan[i].left = {3'h0, c0[`TAT_SET_LSB +: 8]}; // [RULE1] [RULE16]
                        end else if (tick[i]) begin
                            n.chan[i].left = s.chan[i].left - 11'h1;
                        end
                    end
                    TAT_SET: begin
                        if (s.chan[i].left == 11'h0) begin
                            newCnt = s.chan[i].cnt + 16'h1;
                            n.chan[i].cnt = newCnt;
                            if (compIn[i] || newCnt >= c1[`TAT_MAX_LSB +: 16]) begin
                                n.chan[i].phase = TAT_IDLE; // [RULE6]
                                n.chan[i].result = newCnt;
                                n.chan[i].done = 1'b1;
                            end else begin
                                n.chan[i].phase = TAT_CHG;
                                n.chan[i].left = {3'h0, c0[`TAT_CHG_LSB +: 8]};
                            end
                        end else if (tick[i]) begin
                            n.chan[i].left = s.chan[i].left - 11'h1; // [RULE1] [RULE16]
                        end
                    end
                    default: n.chan[i].phase = TAT_IDLE;
                endcase
            end
            n.chan[i].chg = n.chan[i].phase == TAT_CHG;
            n.chan[i].dis = n.chan[i].phase == TAT_DIS;
        end

        for (int k = 0; k < `TAT_PAIRS; k++) begin
            ch = chanOf(pairMode[k]);
            n.pairChg[k] = (ch != 2'd3) && n.chan[ch].chg; // [RULE21]
            n.pairDis[k] = (ch != 2'd3) && n.chan[ch].dis;
        end

        // Drift timers count autonomous sample periods
        // A zero interval parks its timer, so that direction never drifts
        // Each step moves the reference by one count, never while touched
        if (!s.ctrlEn || s.aDrift[`TAT_RISE_LSB +: 8] == 8'h0) begin
            n.riseCnt = 24'h0; // [RULE12]
        end else if (tick[0]) begin
            if (s.riseCnt + 24'h1 >= {s.aDrift[`TAT_RISE_LSB +: 8], 16'h0}) begin
                n.riseCnt = 24'h0;
                if (s.cal && !s.touch && s.chan[0].result > s.refCnt) begin
                    n.refCnt = s.refCnt + 16'h1; // [RULE12]
                end
            end else begin
                n.riseCnt = s.riseCnt + 24'h1;
            end
        end
        // Detection below runs later and wins over a drift step
        if (!s.ctrlEn || s.aDrift[`TAT_FALL_LSB +: 8] == 8'h0) begin
            n.fallCnt = 24'h0; // [RULE13]
        end else if (tick[0]) begin
            if (s.fallCnt + 24'h1 >= {s.aDrift[`TAT_FALL_LSB +: 8], 16'h0}) begin
                n.fallCnt = 24'h0;
                if (s.cal && !s.touch && s.chan[0].result < s.refCnt) begin
                    n.refCnt = s.refCnt - 16'h1; // [RULE13]
                end
            end else begin
                n.fallCnt = s.fallCnt + 24'h1;
            end
        end

        // Detection on each finished autonomous acquisition; touch lowers the count
        if (!s.ctrlEn) begin
            n.cal = 1'b0;
            n.touch = 1'b0;
            n.detCnt = 8'h0;
        end else if (s.chan[0].done) begin
            delta = (s.refCnt > s.chan[0].result) ? s.refCnt - s.chan[0].result : 16'h0;
            if (!s.cal) begin
                n.cal = 1'b1;
                n.refCnt = s.chan[0].result;
            end else if (s.chan[0].result >= s.refCnt &&
                    s.chan[0].result - s.refCnt >= {8'h0, s.aDrift[`TAT_RCAL_LSB +: 8]}) begin
                recalEv = 1'b1;
                n.refCnt = s.chan[0].result; // [RULE11]
                n.detCnt = 8'h0;
            end else if (!s.touch) begin
                if (delta >= {8'h0, s.aDet[`TAT_SENSE_LSB +: 8]}) begin // [RULE10]
                    if (s.detCnt + 8'h1 == {3'h0, s.aDet[`TAT_FILTER_LSB +: 5]}) begin
                        n.touch = 1'b1; // [RULE7] [RULE8]
                        n.detCnt = 8'h0;
                    end else begin
                        n.detCnt = s.detCnt + 8'h1;
                    end
                end else begin
                    n.detCnt = 8'h0;
                end
            end else if (delta < {8'h0, s.aDet[`TAT_REL_LSB +: 8]}) begin
                n.touch = 1'b0; // [RULE9]
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign pairCharge = s.pairChg;
    assign pairDischarge = s.pairDis;
    assign touchState = s.touch;

    // Properties watch the registered state, one per guarded rule

    chk_discharge_load: assert property (@(posedge clk) disable iff (!rst_b) // [RULE5]
        (s.chan[0].phase != TAT_DIS ##1 s.chan[0].phase == TAT_DIS)
        |-> s.chan[0].left == discDur($past(s.aTime)))
        else $error("Discharge length not loaded from shifted field");
    chk_sync_wait: assert property (@(posedge clk) disable iff (!rst_b) // [RULE3]
        (s.chan[0].phase == TAT_SYNC && s.ctrlEn && !(s.syncPrev && !syncIn))
        |=> s.chan[0].phase == TAT_SYNC || !$past(s.ctrlEn))
        else $error("Acquisition left sync wait without falling edge");
    chk_count_cap: assert property (@(posedge clk) disable iff (!rst_b) // [RULE6]
        $rose(s.chan[1].done) && s.gaDis[15:0] != 16'h0
        |-> s.chan[1].result <= s.gaDis[15:0])
        else $error("Acquisition count passed maximum");
    chk_touch_filter: assert property (@(posedge clk) disable iff (!rst_b) // [RULE7]
        $rose(s.touch) |-> $past(s.detCnt) + 8'h1 == {3'h0, $past(s.aDet[20:16])})
        else $error("Touch reported before filter count");
    chk_recal_ref: assert property (@(posedge clk) disable iff (!rst_b) // [RULE11]
        recalEv |=> s.refCnt == $past(s.chan[0].result))
        else $error("Reference not recalibrated");
    chk_rise_drift_off: assert property (@(posedge clk) disable iff (!rst_b) // [RULE12]
        s.aDrift[15:8] == 8'h0 |=> s.riseCnt == 24'h0)
        else $error("Rising drift timer runs while disabled");
    chk_fall_drift_off: assert property (@(posedge clk) disable iff (!rst_b) // [RULE13]
        s.aDrift[7:0] == 8'h0 |=> s.fallCnt == 24'h0)
        else $error("Falling drift timer runs while disabled");
    chk_prescale_bound: assert property (@(posedge clk) disable iff (!rst_b) // [RULE14]
        s.chan[1].pre >= preTerm(s.gaClk) |=> s.chan[1].pre == 17'h0)
        else $error("Group A prescaler ran past its terminal count");
    chk_pair_disabled: assert property (@(posedge clk) disable iff (!rst_b) // [RULE21]
        ##1 (s.pairChg & $past(disMask)) == 17'h0)
        else $error("Disabled sense pair driven");
    chk_spread_tick: assert property (@(posedge clk) disable iff (!rst_b) // [RULE4]
        s.ctrlEn && s.aTime[24] && s.chan[0].lfsr[0] && s.chan[0].pre + 17'h1 == preTerm(s.aClk)
        |=> s.chan[0].pre == 17'h0)
        else $error("Spread drive did not shorten the sample period");

endmodule

// ==== tat_consts.svh ====
// Purpose: Offsets, field positions, masks and reset values of the touch timing block
// Assumes: 32-bit APB data, one aligned word per register
// Notes: Definitions only
`ifndef TAT_CONSTS_SVH
`define TAT_CONSTS_SVH

`define TAT_OFF_CTRL 8'h00
`define TAT_OFF_PMODE0 8'h08
`define TAT_OFF_PMODE1 8'h0c
`define TAT_OFF_ACLK 8'h10
`define TAT_OFF_ATIME 8'h14
`define TAT_OFF_ADET 8'h18
`define TAT_OFF_ADRIFT 8'h1c
`define TAT_OFF_GACLK 8'h20
`define TAT_OFF_GADIS 8'h24
`define TAT_OFF_GBCLK 8'h28
`define TAT_OFF_GBDIS 8'h2c
`define TAT_OFF_STATUS 8'h3c
`define TAT_OFF_COUNTS 8'h54
`define TAT_OFF_BASE 8'h6c
`define TAT_OFF_CURR 8'h70
`define TAT_OFF_PMODE2 8'h74

`define TAT_RST_VAL 32'h0000_0000
`define TAT_MASK_TIME 32'h33ff_ffff
`define TAT_MASK_DET 32'h001f_ffff
`define TAT_MASK_DRIFT 32'h00ff_ffff

`define TAT_DIV_LSB 16
`define TAT_CHG_LSB 8
`define TAT_SET_LSB 0
`define TAT_SHIFT_LSB 28
`define TAT_SYNC_BIT 25
`define TAT_SPREAD_BIT 24
`define TAT_DLEN_LSB 16
`define TAT_MAX_LSB 0
`define TAT_FILTER_LSB 16
`define TAT_REL_LSB 8
`define TAT_SENSE_LSB 0
`define TAT_RCAL_LSB 16
`define TAT_RISE_LSB 8
`define TAT_FALL_LSB 0
`define TAT_DRIFT_SCALE_BITS 16

`define TAT_MODE_OFF 3'h0
`define TAT_MODE_GRPA 3'h1
`define TAT_MODE_GRPB 3'h2
`define TAT_MODE_DMA 3'h4
`define TAT_PAIRS 17

`endif

// ==== tat_pkg.sv ====
// Purpose: Types of the touch timing block
// Assumes: Three acquisition channels: autonomous/DMA, group A, group B
// Notes: Constants live in tat_consts.svh
package tat_pkg;

    typedef enum logic [2:0] {
        TAT_IDLE,
        TAT_SYNC,
        TAT_DIS,
        TAT_CHG,
        TAT_SET
    } tat_phase_t;

    typedef struct packed {
        tat_phase_t phase;
        logic [16:0] pre;
        logic [10:0] left;
        logic [15:0] cnt;
        logic [15:0] result;
        logic done;
        logic chg;
        logic dis;
        logic [15:0] lfsr;
    } tat_chan_t;

    typedef struct packed {
        logic ctrlEn;
        logic [16:0] pmode0;
        logic [16:0] pmode1;
        logic [16:0] pmode2;
        logic [31:0] aClk;
        logic [31:0] aTime;
        logic [31:0] aDet;
        logic [31:0] aDrift;
        logic [31:0] gaClk;
        logic [31:0] gaDis;
        logic [31:0] gbClk;
        logic [31:0] gbDis;
        tat_chan_t [2:0] chan;
        logic [15:0] refCnt;
        logic cal;
        logic [7:0] detCnt;
        logic touch;
        logic [23:0] riseCnt;
        logic [23:0] fallCnt;
        logic syncPrev;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [16:0] pairChg;
        logic [16:0] pairDis;
    } tat_state_t;

endpackage

// ==== tat_sense_model.sv ====
// Purpose: Comparator model for sense pairs 0 to 2, one pair per channel
// Assumes: Pair n carries channel n; a discharge empties the sense capacitor
// Notes: Output rises once transfers since the last discharge reach the limit
`timescale 1ns/1ns
module tat_sense_model (
    input wire logic clk, // Module clock
    input wire logic rst_b, // Reset, active low
    input wire logic [16:0] pairCharge, // Charge drive from the block
    input wire logic [16:0] pairDischarge, // Discharge drive from the block
    input wire logic [23:0] limit, // Three 8-bit transfer limits
    output logic [2:0] compIn // Comparator outputs
);
    logic [7:0] level [3];
    logic [2:0] prevChg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prevChg <= 3'h0;
            for (int i = 0; i < 3; i++) level[i] <= 8'h00;
        end else begin
            prevChg <= pairCharge[2:0];
            for (int i = 0; i < 3; i++) begin
                if (pairDischarge[i]) level[i] <= 8'h00;
                else if (pairCharge[i] && !prevChg[i] && level[i] != 8'hff)
                    level[i] <= level[i] + 8'h01;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < 3; i++) compIn[i] = level[i] >= limit[8*i +: 8];
    end
endmodule

// ==== touch_acquisition_timing_config_tb.sv ====
// Purpose: Self-checking bench for the touch timing block
// Assumes: 50 MHz clock, APB slave answering after one wait state
// Notes: Phase lengths are counted in clocks at the falling edge
`timescale 1ns/1ns
`include "tat_consts.svh"
module touch_acquisition_timing_config_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic syncIn = 1'b1;
    logic [2:0] compIn;
    logic [16:0] pairCharge;
    logic [16:0] pairDischarge;
    logic touchState;
    logic [23:0] limit = 24'hffffff;
    logic badDrive = 1'b0;
    int num_errors = 0;
    int samples_checked = 0;
    always #10 clk = ~clk;
    tat_timing i_tat_timing (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .syncIn(syncIn), .compIn(compIn), .pairCharge(pairCharge),
        .pairDischarge(pairDischarge), .touchState(touchState));
    tat_sense_model i_tat_sense_model (.clk(clk), .rst_b(rst_b), .pairCharge(pairCharge),
        .pairDischarge(pairDischarge), .limit(limit), .compIn(compIn));
    // Pairs 3 and up hold matrix, reserved or disabled codes
    always @(negedge clk) if (|{pairCharge[16:3], pairDischarge[16:3]}) badDrive <= 1'b1;
    task automatic tally_and_finish;
        $display("Checks %0d, errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chkn(input string name, input int exp, input int got, input int tol);
        samples_checked++;
        if (got < exp - tol || got > exp + tol) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            tally_and_finish;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(name, exp, r);
    endtask
    task automatic run_len(input int p, input logic ch, input logic lvl, input int lim,
        output int len);
        len = 0;
        while ((ch ? pairCharge[p] : pairDischarge[p]) === lvl && len < lim) begin
            @(negedge clk);
            len++;
        end
    endtask
    task automatic meas(input int p, input int ed, input int ec, input int es, input int em);
        int d, c, s, x, n;
        logic prev;
        @(negedge clk);
        run_len(p, 1'b0, 1'b1, 4000, x);
        run_len(p, 1'b0, 1'b0, 4000, x);
        run_len(p, 1'b0, 1'b1, 4000, d);
        run_len(p, 1'b1, 1'b0, 4000, x);
        run_len(p, 1'b1, 1'b1, 4000, c);
        run_len(p, 1'b1, 1'b0, 4000, s);
        n = 2;
        x = 0;
        while (pairDischarge[p] !== 1'b1 && x < 4000) begin
            prev = pairCharge[p];
            @(negedge clk);
            if (pairCharge[p] && !prev) n++;
            x++;
        end
        chkn("discharge clocks", ed, d, 2);
        chkn("charge clocks", ec, c, 2);
        chkn("settle clocks", es, s, 2);
        chkn("transfers per burst", em, n, 0);
    endtask
    task automatic falls_until(input logic lvl, output int n);
        logic prev;
        int k;
        n = 0;
        prev = 1'b0;
        for (k = 0; k < 4000; k++) begin
            @(negedge clk);
            if (!pairDischarge[0] && prev) begin
                n++;
                if (touchState === lvl) break;
            end
            prev = pairDischarge[0];
        end
    endtask
    task automatic test_regs;
        logic [7:0] offs [7] = '{`TAT_OFF_ATIME, `TAT_OFF_ADET, `TAT_OFF_ADRIFT,
            `TAT_OFF_GACLK, `TAT_OFF_GADIS, `TAT_OFF_GBCLK, `TAT_OFF_GBDIS};
        logic [31:0] msk [7] = '{`TAT_MASK_TIME, `TAT_MASK_DET, `TAT_MASK_DRIFT,
            32'hffffffff, `TAT_MASK_TIME, 32'hffffffff, `TAT_MASK_TIME};
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 7; i++) rdchk("reset value", offs[i], `TAT_RST_VAL);
        for (int i = 0; i < 7; i++) begin
            wr(offs[i], 32'hffffffff);
            rdchk("read back", offs[i], msk[i]);
        end
        apb(1'b0, 8'hf0, 32'h0, r, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
    endtask
    task automatic test_timing;
        wr(`TAT_OFF_ADET, 32'h0003_0102);
        wr(`TAT_OFF_ADRIFT, 32'h00ff_0000);
        wr(`TAT_OFF_ACLK, 32'h0000_0203);
        wr(`TAT_OFF_ATIME, 32'h1002_0003);
        wr(`TAT_OFF_GACLK, 32'h0001_0102);
        wr(`TAT_OFF_GADIS, 32'h2001_0002);
        wr(`TAT_OFF_GBCLK, 32'h0000_0301);
        wr(`TAT_OFF_GBDIS, 32'h0005_0004);
        wr(`TAT_OFF_PMODE0, 32'h0000_001a);
        wr(`TAT_OFF_PMODE1, 32'h0000_000c);
        wr(`TAT_OFF_PMODE2, 32'h0000_0011);
        wr(`TAT_OFF_CTRL, 32'h0000_0001);
        meas(0, 8, 4, 6, 3);
        meas(1, 16, 4, 8, 2);
        meas(2, 10, 6, 2, 4);
        rdchk("auto count", `TAT_OFF_CURR, 32'h3);
        chk("unassigned pairs", 32'h0, {31'h0, badDrive});
    endtask
    task automatic test_sync;
        int w;
        wr(`TAT_OFF_ATIME, 32'h1302_0003);
        repeat (100) @(posedge clk);
        @(negedge clk);
        run_len(0, 1'b0, 1'b0, 200, w);
        chkn("start held for sync", 200, w, 0);
        @(posedge clk);
        syncIn <= 1'b0;
        @(negedge clk);
        run_len(0, 1'b0, 1'b0, 20, w);
        chkn("start after sync fall", 2, w, 2);
        wr(`TAT_OFF_ATIME, 32'h1002_0003);
    endtask
    task automatic test_touch;
        int n;
        chk("touch idle", 32'h0, {31'h0, touchState});
        @(negedge clk);
        run_len(0, 1'b0, 1'b0, 4000, n);
        @(posedge clk);
        limit <= 24'hffff01;
        falls_until(1'b1, n);
        chkn("bursts before touch", 4, n, 0);
        @(negedge clk);
        run_len(0, 1'b0, 1'b0, 4000, n);
        @(posedge clk);
        limit <= 24'hffffff;
        falls_until(1'b0, n);
        chkn("bursts before release", 3, n, 1);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        test_regs;
        test_timing;
        test_sync;
        test_touch;
        tally_and_finish;
    end
    initial begin
        #400000;
        num_errors++;
        tally_and_finish;
    end
endmodule
